// [imc_top.sv]
/*
  imc_top: input multiplexer and odd/even sampling phase control
  for sixteen synchronous converters in 8, 16 or 32 input mode.
  Assumes sync_trigger arrives asynchronously on a pin; mode and
  selections come from the control port and stay static.
*/
// Summary of operation
// - sixteen converters sample together except in 8-input mode; mode picks 8, 16 or 32 inputs
// - each converter has odd and even circuits, converted alternately
// - all sampling windows come from the one system clock
// - pin pairs route to odd/even circuits by mode, pattern repeats
// - 16-input mode: one odd pin per converter, both circuits ping-pong
// - 16-input mode: per-converter bit moves it to the even pin
// - 32-input mode: two inputs per converter, each at half rate
// - 32-input mode: even input sampled one clock after odd input
// - 8-input mode: adjacent converters interleave, each on its own odd pin
// - sync trigger fixes which clock edges sample odd or even
// - 8-input mode converts at half clock, phase set by trigger
`timescale 1ns/10ps
module imc_top (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // configuration
  input  wire imc_pkg::imc_mode_t          input_mode,
  input  wire logic [imc_pkg::NUM_CONV-1:0] even_input_select_per_converter,
  // synchronisation pin
  input  wire logic                        sync_trigger,
  // sampling control
  output logic [imc_pkg::NUM_CONV-1:0]     odd_sample_strobe,
  output logic [imc_pkg::NUM_CONV-1:0]     even_sample_strobe,
  output logic [imc_pkg::NUM_CONV-1:0][imc_pkg::PIN_W-1:0] odd_pin_select,
  output logic [imc_pkg::NUM_CONV-1:0][imc_pkg::PIN_W-1:0] even_pin_select,
  // status
  output logic                             synced_reg,
  output logic                             config_pending_reg
);
  import imc_pkg::*;

  imc_phase_if ph ();

  logic [SYNC_STAGES-1:0] trig_sync_reg;
  logic                   trig_level_reg;
  logic                   trig_pulse;
  logic [PHASE_W-1:0]     phase_reg;
  logic [PHASE_W-1:0]     phase_next;
  imc_mode_t              mode_reg;
  imc_mode_t              mode_next;
  logic [NUM_CONV-1:0]    sel_reg;

  // ------------------------------------------------------------
  // trigger synchroniser and edge
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trig_sync_reg <= SYNC_RST;
    end else begin
      trig_sync_reg <= {trig_sync_reg[SYNC_STAGES-2:0], sync_trigger};
    end
  end

  // level changes once stages two and three agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trig_level_reg <= 1'b0;
    end else if (trig_sync_reg[1] == trig_sync_reg[2]) begin
      trig_level_reg <= trig_sync_reg[2];
    end
  end

  assign trig_pulse = trig_sync_reg[1] & trig_sync_reg[2] & ~trig_level_reg;

  // ------------------------------------------------------------
  // sampling phase counter
  // ------------------------------------------------------------
  always_comb begin
    if (trig_pulse) begin
      phase_next = PHASE_RST;
    end else begin
      phase_next = phase_reg + PHASE_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_reg <= PHASE_RST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ------------------------------------------------------------
  // held configuration
  // ------------------------------------------------------------
  always_comb begin
    unique case (input_mode)
      imc_mode_16: mode_next = imc_mode_16;
      imc_mode_32: mode_next = imc_mode_32;
      imc_mode_8:  mode_next = imc_mode_8;
      default:     mode_next = imc_mode_16;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_reg <= MODE_RST;
      sel_reg  <= SEL_RST;
    end else if (trig_pulse) begin
      mode_reg <= mode_next;
      sel_reg  <= even_input_select_per_converter;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      synced_reg <= 1'b0;
    end else if (trig_pulse) begin
      synced_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      config_pending_reg <= 1'b0;
    end else begin
      config_pending_reg <= (mode_next != mode_reg)
        || (even_input_select_per_converter != sel_reg);
    end
  end

  assign ph.mode   = mode_reg;
  assign ph.phase  = phase_reg;
  assign ph.trig   = trig_pulse;
  assign ph.synced = synced_reg;

  // ------------------------------------------------------------
  // converter lanes
  // ------------------------------------------------------------
  for (genvar c = 0; c < NUM_CONV; c++) begin : g_lane
    imc_lane #(.LANE(c)) u_lane (
      .clk             (clk),
      .sys_rst         (sys_rst),
      .ph              (ph),
      .even_sel        (sel_reg[c]),
      .odd_strobe_reg  (odd_sample_strobe[c]),
      .even_strobe_reg (even_sample_strobe[c]),
      .odd_pin_reg     (odd_pin_select[c]),
      .even_pin_reg    (even_pin_select[c])
    );
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_trig_phase_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    trig_pulse |=> (phase_reg == PHASE_RST && synced_reg))
    else $error("trigger did not restart sampling phase");

  a_phase_advance: assert property (
    @(posedge clk) disable iff (sys_rst)
    !trig_pulse |=> (phase_reg == PHASE_W'($past(phase_reg) + PHASE_STEP)))
    else $error("sampling phase did not advance one per clock");

  a_cfg_static: assert property (
    @(posedge clk) disable iff (sys_rst)
    !trig_pulse |=> ($stable(mode_reg) && $stable(sel_reg)))
    else $error("held configuration changed without trigger");

  a_cfg_load: assert property (
    @(posedge clk) disable iff (sys_rst)
    trig_pulse |=> (sel_reg == $past(even_input_select_per_converter)))
    else $error("selection not loaded on trigger");

  a_trig_once: assert property (
    @(posedge clk) disable iff (sys_rst)
    trig_pulse |=> !trig_pulse)
    else $error("trigger pulse longer than one clock");

  a_sync_stays: assert property (
    @(posedge clk) disable iff (sys_rst)
    synced_reg |=> synced_reg)
    else $error("synced flag dropped without reset");

  a_gate_until_sync: assert property (
    @(posedge clk) disable iff (sys_rst)
    !synced_reg |=> (!(|odd_sample_strobe) && !(|even_sample_strobe)))
    else $error("sampling strobe before first trigger");

  a_lanes_together: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode_reg != imc_mode_8)
      |=> (((&odd_sample_strobe) || !(|odd_sample_strobe))
           && ((&even_sample_strobe) || !(|even_sample_strobe))))
    else $error("converters not sampling together");

  a_full_rate_16: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode_reg == imc_mode_16 && synced_reg)
      |=> (odd_sample_strobe[0] ^ even_sample_strobe[0]))
    else $error("sixteen-input converter missed a clock");

  sequence s_skip_one;
    !odd_sample_strobe[0] ##1 odd_sample_strobe[0];
  endsequence

  a_half_rate_32: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode_reg == imc_mode_32 && $stable(mode_reg) && odd_sample_strobe[0]
     && !trig_pulse && !$past(trig_pulse))
      |=> s_skip_one)
    else $error("thirty-two input rate not half clock");

  a_pair_interleave: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mode_reg == imc_mode_8 && $stable(mode_reg) && odd_sample_strobe[0]
     && !trig_pulse && !$past(trig_pulse))
      |=> (odd_sample_strobe[1] && !odd_sample_strobe[0]))
    else $error("adjacent converters not interleaved");

  sequence s_load_quiet;
    trig_pulse ##1 ($stable(input_mode)
      && $stable(even_input_select_per_converter));
  endsequence

  a_pending_clear: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_load_quiet |=> !config_pending_reg)
    else $error("pending flag stayed up after reload");
endmodule

// [imc_pkg.sv]
/*
  imc_pkg: constants and types for the input multiplexer and
  sampling phase control of a sixteen-converter front end.
  Assumes one system clock and a synchronous active-high reset.
*/
package imc_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_CONV    = 16;
  localparam int NUM_PINS    = 32;
  localparam int PIN_W       = 5;
  localparam int PHASE_W     = 2;
  localparam int SYNC_STAGES = 3;

  // ------------------------------------------------------------
  // reset values and phase step
  // ------------------------------------------------------------
  localparam logic [PHASE_W-1:0]  PHASE_RST  = 2'h0;
  localparam logic [PHASE_W-1:0]  PHASE_STEP = 2'h1;
  localparam logic [NUM_CONV-1:0] SEL_RST    = 16'h0000;
  localparam logic [SYNC_STAGES-1:0] SYNC_RST = 3'h0;

  // ------------------------------------------------------------
  // input modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    imc_mode_16,
    imc_mode_32,
    imc_mode_8
  } imc_mode_t;

  localparam imc_mode_t MODE_RST = imc_mode_16;

endpackage

// [imc_phase_if.sv]
/*
  imc_phase_if: timing and held configuration shared from the
  phase generator to every converter lane.
  Assumes all signals run on the system clock.
*/
`timescale 1ns/10ps
interface imc_phase_if;
  import imc_pkg::*;

  imc_mode_t            mode;
  logic [PHASE_W-1:0]   phase;
  logic                 trig;
  logic                 synced;

  modport src  (output mode, output phase, output trig, output synced);
  modport lane (input mode, input phase, input trig, input synced);
endinterface

// [imc_lane.sv]
/*
  imc_lane: odd and even sampling strobes and pin selection for
  one converter.
  Assumes phase and held mode from the shared phase interface.
*/
`timescale 1ns/10ps
module imc_lane #(
  parameter int LANE = 0
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // shared timing
  imc_phase_if.lane              ph,
  // per-converter control
  input  wire logic              even_sel,
  // sampling control
  output logic                   odd_strobe_reg,
  output logic                   even_strobe_reg,
  output logic [imc_pkg::PIN_W-1:0] odd_pin_reg,
  output logic [imc_pkg::PIN_W-1:0] even_pin_reg
);
  import imc_pkg::*;

  localparam logic [PIN_W-1:0] PIN_LO = PIN_W'(2 * LANE);
  localparam logic [PIN_W-1:0] PIN_HI = PIN_W'(2 * LANE + 1);
  localparam logic             PARITY = 1'(LANE % 2);

  logic             odd_next;
  logic             even_next;
  logic [PIN_W-1:0] odd_pin_next;
  logic [PIN_W-1:0] even_pin_next;

  // ------------------------------------------------------------
  // sampling phase per mode
  // ------------------------------------------------------------
  always_comb begin
    odd_next      = 1'b0;
    even_next     = 1'b0;
    odd_pin_next  = PIN_LO;
    even_pin_next = PIN_LO;
    unique case (ph.mode)
      imc_mode_8: begin
        // pair interleaves, each lane on its own odd pin, four circuits in turn
        odd_next  = (ph.phase == {1'b0, PARITY});
        even_next = (ph.phase == {1'b1, PARITY});
      end
      imc_mode_32: begin
        odd_next      = ~ph.phase[0];
        even_next     = ph.phase[0];
        even_pin_next = PIN_HI;
      end
      default: begin
        // both circuits ping-pong on one pin
        odd_next  = ~ph.phase[0];
        even_next = ph.phase[0];
        if (even_sel) begin
          odd_pin_next  = PIN_HI;
          even_pin_next = PIN_HI;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      odd_strobe_reg  <= 1'b0;
      even_strobe_reg <= 1'b0;
    end else begin
      odd_strobe_reg  <= odd_next & ph.synced;
      even_strobe_reg <= even_next & ph.synced;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      odd_pin_reg  <= PIN_LO;
      even_pin_reg <= PIN_LO;
    end else begin
      odd_pin_reg  <= odd_pin_next;
      even_pin_reg <= even_pin_next;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || ph.trig);

  sequence s_odd_then_even;
    odd_strobe_reg ##1 (even_strobe_reg && !odd_strobe_reg);
  endsequence

  sequence s_div_two;
    (!odd_strobe_reg && !even_strobe_reg) ##1 even_strobe_reg;
  endsequence

  a_ping_pong_alt: assert property (
    (odd_strobe_reg && ph.mode != imc_mode_8 && $stable(ph.mode)
     && !ph.trig && !$past(ph.trig))
      |-> s_odd_then_even)
    else $error("odd sample not followed by even sample");

  a_even_one_clk: assert property (
    (ph.mode == imc_mode_32 && odd_strobe_reg && $stable(ph.mode)
     && !ph.trig && !$past(ph.trig))
      |=> (even_strobe_reg && even_pin_reg == PIN_HI))
    else $error("even input not sampled one clock after odd");

  a_div_by_two: assert property (
    (ph.mode == imc_mode_8 && odd_strobe_reg && $stable(ph.mode)
     && !ph.trig && !$past(ph.trig))
      |=> s_div_two)
    else $error("eight-input conversion not at half clock");

  a_pin_map_32: assert property (
    (ph.mode == imc_mode_32 && $stable(ph.mode))
      |=> (odd_pin_reg == PIN_LO && even_pin_reg == PIN_HI))
    else $error("thirty-two input pin mapping wrong");

  a_same_pin_16: assert property (
    (ph.mode == imc_mode_16 && $stable(ph.mode) && $stable(even_sel))
      |=> (odd_pin_reg == even_pin_reg
           && odd_pin_reg == ($past(even_sel) ? PIN_HI : PIN_LO)))
    else $error("sixteen-input pin selection wrong");

  a_no_both_samp: assert property (
    !(odd_strobe_reg && even_strobe_reg))
    else $error("odd and even sampled together");
endmodule

// [imc_trig_src.sv]
/*
  imc_trig_src: board-side source that drives the sync trigger pin.
  Assumes the bench calls fire at a quiet point between checks.
*/
`timescale 1ns/10ps
module imc_trig_src (
  // clock
  input  wire logic clk,
  // trigger pin
  output logic      sync_trigger
);
  initial sync_trigger = 1'b0;

  // ------------------------------------------------------------
  // trigger pulse, changed at falling edges only
  // ------------------------------------------------------------
  task automatic fire(input int width);
    @(negedge clk);
    sync_trigger = 1'b1;
    repeat (width) @(negedge clk);
    sync_trigger = 1'b0;
  endtask
endmodule

// [tb.sv]
/*
  tb: self-checking bench for imc_top in every input mode.
  Assumes imc_pkg and the trigger source model are compiled first.
*/
`timescale 1ns/10ps
module tb;
  import imc_pkg::*;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic                           clk;
  logic                           sys_rst;
  logic                           sync_trigger;
  logic                           synced_reg;
  logic                           config_pending_reg;
  imc_mode_t                      input_mode;
  logic [NUM_CONV-1:0]            sel;
  logic [NUM_CONV-1:0]            odd_s;
  logic [NUM_CONV-1:0]            even_s;
  logic [NUM_CONV-1:0][PIN_W-1:0] odd_p;
  logic [NUM_CONV-1:0][PIN_W-1:0] even_p;
  logic [31:0]                    rng;
  logic [31:0]                    q[$];
  int                             err_total;
  int                             compares;

  imc_top dut (
    .clk                             (clk),
    .sys_rst                         (sys_rst),
    .input_mode                      (input_mode),
    .even_input_select_per_converter (sel),
    .sync_trigger                    (sync_trigger),
    .odd_sample_strobe               (odd_s),
    .even_sample_strobe              (even_s),
    .odd_pin_select                  (odd_p),
    .even_pin_select                 (even_p),
    .synced_reg                      (synced_reg),
    .config_pending_reg              (config_pending_reg)
  );

  imc_trig_src src (
    .clk          (clk),
    .sync_trigger (sync_trigger)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // pin mapping model, mode 3 taken as 16-input
  task automatic chk_pins(input int m, input logic [15:0] s);
    int c;
    int e;
    for (c = 0; c < NUM_CONV; c++) begin
      e = 2 * c + ((m == 0 || m == 3) ? int'(s[c]) : 0);
      chk("odd_pin", odd_p[c], (m == 1) ? 2 * c : e);
      chk("even_pin", even_p[c], (m == 1) ? 2 * c + 1 : e);
    end
  endtask

  // strobe model over eight clocks, queued then compared
  task automatic chk_run(input int m);
    int k;
    int c;
    logic [31:0] v;
    for (k = 0; k < 8; k++) begin
      for (c = 0; c < NUM_CONV; c++) begin
        if (m == 2) begin
          v[c] = (k % 4 == c % 2);
          v[16 + c] = (k % 4 == 2 + c % 2);
        end else begin
          v[c] = (k % 2 == 0);
          v[16 + c] = (k % 2 == 1);
        end
      end
      q.push_back(v);
    end
    for (k = 0; k < 8; k++) begin
      v = q.pop_front();
      chk("odd_strobe", odd_s, v[15:0]);
      chk("even_strobe", even_s, v[31:16]);
      @(negedge clk);
    end
  endtask

  // ------------------------------------------------------------
  // clock and sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    int m;
    int pm;
    logic [15:0] s;
    logic [15:0] ps;
    sys_rst = 1'b1;
    input_mode = imc_mode_16;
    sel = 16'h0000;
    rng = 32'h5810;
    err_total = 0;
    compares = 0;
    pm = 0;
    ps = 16'h0000;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("synced", synced_reg, 0);
    chk("odd_strobe", odd_s, 0);
    chk_pins(0, 16'h0000);
    for (m = 0; m < 4; m++) begin
      rng = xs(rng);
      s = rng[15:0];
      input_mode = imc_mode_t'(m);
      sel = s;
      repeat (2) @(negedge clk);
      chk("pending", config_pending_reg, 1);
      chk_pins(pm, ps);
      src.fire(3);
      repeat (2) @(negedge clk);
      chk("synced", synced_reg, 1);
      chk_pins(m, s);
      chk_run(m);
      chk("pending", config_pending_reg, 0);
      // restart the phase at a random point, same setup
      rng = xs(rng);
      repeat (int'(rng[2:0])) @(negedge clk);
      src.fire(3);
      repeat (2) @(negedge clk);
      chk_run(m);
      chk_pins(m, s);
      pm = m;
      ps = s;
    end
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk("synced", synced_reg, 0);
    chk("even_strobe", even_s, 0);
    chk_pins(0, 16'h0000);
    test_done();
  end
endmodule
